// ### logic/dsp_regs.vh
// Register map, field layout, commands and timing names for the DRAM block.
`ifndef DSP_REGS_VH
`define DSP_REGS_VH
// Register byte addresses.
`define DSP_A_CTRL 8'h00
`define DSP_A_DENS 8'h04
`define DSP_A_ROW 8'h08
`define DSP_A_COL 8'h0c
`define DSP_A_STAT 8'h10
// Control register fields.
`define DSP_F_TYPE 1:0
`define DSP_F_X32 2
`define DSP_F_ADV 3
`define DSP_F_DEVW 4
// Density register fields.
`define DSP_F_DEN 2:0
`define DSP_F_SPD 5:3
// Reset values.
`define DSP_CTRL_RST 8'h00
`define DSP_DENS_RST 8'h1a
`define DSP_GEOM_RST 8'h0e
// Memory families.
`define DSP_T_DDR3 2'h0
`define DSP_T_LP2 2'h1
`define DSP_T_LP3 2'h2
// Density codes 256M, 512M, 1G, 2G, 4G, 8G and speed codes 400 to 1066.
`define DSP_D_256M 3'h0
`define DSP_D_1G 3'h2
`define DSP_D_4G 3'h4
`define DSP_D_8G 3'h5
`define DSP_S_800 3'h3
`define DSP_S_1066 3'h4
`define DSP_ROW_BASE 7'h0b
`define DSP_COL_DFLT 7'h0a
// Commands as {cs_n, ras_n, cas_n, we_n}.
`define DSP_CMD_NOP 4'h7
`define DSP_CMD_ACT 4'h3
`define DSP_CMD_RD 4'h5
`define DSP_CMD_WR 4'h4
`define DSP_CMD_PRE 4'h2
`define DSP_CMD_MRS 4'h0
`define DSP_CMD_ZQ 4'h6
`define DSP_CMD_DES 4'hf
// Timing figures.
`define DSP_CLK_MHZ 200
`define DSP_T_RST_US 200
`define DSP_T_CKE_US 500
`define DSP_T_MRD_CK 4
`define DSP_T_ZQ_CK 512
`define DSP_T_RCD_CK 8
`define DSP_BURST_CK 4
`define DSP_T_RP_CK 8
`define DSP_MR_LAST 2'h3
`endif

// ### logic/dsp_top.v
// DRAM startup sequencer, configuration port and memory pad drivers.
// Summary of operation
// - Start input launches the memory startup sequence.
// - Master reset low forces full reinitialisation.
// - Memory clock pair runs at half the controller clock.
// - Device drives data and strobes only writing.
// - Data bus 16 or 32 bits by setting.
// - Active-high mask, one bit per lane.
// - RAS, CAS, WE, chip select active low.
// - Clock enable output is active high.
// - Memory reset output is active low.
// - 16-bit address and 3-bit bank outputs.
// - DDR3, LPDDR2 or LPDDR3 chosen by setting.
// - Advanced density takes explicit row, column widths.
// - LPDDR2 400-1066; LPDDR3 800/1066, 4G/8G.
`timescale 1ns/1ps
`include "dsp_regs.vh"
module dsp_top #(
   parameter DQ_W = 32,
   parameter SER_ADDR = 7'h2a,
   parameter RST_CK = `DSP_T_RST_US * `DSP_CLK_MHZ / 2,
   parameter CKE_CK = `DSP_T_CKE_US * `DSP_CLK_MHZ / 2,
   parameter RD_LAT = 6,
   parameter WR_LAT = 5
) (
   input wire clk,
   input wire reset_n,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire startup_ctrl_reset,
   input wire startup_ctrl_go,
   input wire mem_master_reset_n,
   input wire cfg_serial_clk_in,
   input wire cfg_serial_data_in,
   output reg cfg_serial_data_drive_en,
   input wire usr_req,
   input wire usr_we,
   input wire [2:0] usr_bank,
   input wire [15:0] usr_row,
   input wire [15:0] usr_col,
   input wire [DQ_W-1:0] usr_wdata,
   input wire [DQ_W/8-1:0] usr_wmask,
   output reg [DQ_W-1:0] usr_rdata,
   output reg usr_done,
   output reg usr_busy,
   output reg mem_ready,
   output reg mem_clock_p,
   output reg mem_clock_n,
   output reg mem_cke,
   output reg mem_cs_n,
   output reg mem_ras_n,
   output reg mem_cas_n,
   output reg mem_we_n,
   output reg mem_reset_n,
   output reg mem_termination_ctl,
   output reg [15:0] mem_addr,
   output reg [2:0] mem_bank,
   output reg [DQ_W/8-1:0] mem_byte_mask,
   output reg [DQ_W-1:0] mem_dq_out,
   output reg [DQ_W-1:0] mem_dq_oe,
   input wire [DQ_W-1:0] mem_dq_in,
   output reg [DQ_W/8-1:0] mem_dqs_p_out,
   output reg [DQ_W/8-1:0] mem_dqs_n_out,
   output reg [DQ_W/8-1:0] mem_dqs_oe
);
   localparam LN = DQ_W / 8;
   localparam S_IDLE = 4'h0;
   localparam S_RST = 4'h1;
   localparam S_CKE = 4'h2;
   localparam S_MRS = 4'h3;
   localparam S_ZQ = 4'h4;
   localparam S_READY = 4'h5;
   localparam S_ACT = 4'h6;
   localparam S_XFER = 4'h7;
   localparam S_PRE = 4'h8;

   reg [7:0] ctrl_q, dens_q, row_q, col_q;
   reg [3:0] st_q;
   reg [19:0] cnt_q;
   reg [1:0] mr_q;
   reg we_q, err_q;
   reg [DQ_W-1:0] dq_s1_q, dq_s2_q;
   reg [2:0] scl_s_q, sda_s_q;
   reg scl_q, sda_q, ser_act_q, ser_ack_q;
   reg [3:0] bit_q;
   reg [1:0] byte_q;
   reg [7:0] sh_q, ser_ra_q, ser_wd_q;
   reg ser_wr_q;
   reg [6:0] eff_row, eff_col;
   reg cfg_ok;
   reg [LN-1:0] lane_en;
   reg [3:0] cmd;
   integer i;
   integer j;

   wire [1:0] mtype = ctrl_q[`DSP_F_TYPE];
   wire [2:0] den = dens_q[`DSP_F_DEN];
   wire [2:0] spd = dens_q[`DSP_F_SPD];
   wire tick = mem_clock_p;
   wire hold = startup_ctrl_reset | ~mem_master_reset_n;
   wire scl_rise = (scl_s_q[2] == scl_s_q[1]) && scl_s_q[1] && !scl_q;
   wire scl_fall = (scl_s_q[2] == scl_s_q[1]) && !scl_s_q[1] && scl_q;
   wire sda_new = (sda_s_q[2] == sda_s_q[1]) ? sda_s_q[1] : sda_q;
   wire ser_start = scl_q && sda_q && !sda_new;
   wire ser_stop = scl_q && !sda_q && sda_new;

   // Geometry from density unless advanced widths are enabled.
   always @* begin
      if (ctrl_q[`DSP_F_ADV]) begin
         eff_row = row_q[6:0];
         eff_col = col_q[6:0];
      end else begin
         eff_row = `DSP_ROW_BASE + {4'h0, den};
         eff_col = `DSP_COL_DFLT;
      end
   end

   // Combinations outside the supported set block the startup.
   always @* begin
      case (mtype)
         `DSP_T_DDR3: cfg_ok = (den >= `DSP_D_1G) && (den <= `DSP_D_8G) &&
            (spd >= `DSP_S_800) && (spd <= `DSP_S_1066);
         `DSP_T_LP2: cfg_ok = (den <= `DSP_D_4G) && (spd <= `DSP_S_1066);
         `DSP_T_LP3: cfg_ok = (den >= `DSP_D_4G) && (den <= `DSP_D_8G) &&
            (spd >= `DSP_S_800) && (spd <= `DSP_S_1066);
         default: cfg_ok = 1'b0;
      endcase
   end

   always @* begin
      for (j = 0; j < LN; j = j + 1)
         lane_en[j] = ctrl_q[`DSP_F_X32] || (j < 2);
   end

   // Register file, written by the bus or the serial port.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= `DSP_CTRL_RST;
         dens_q <= `DSP_DENS_RST;
         row_q <= `DSP_GEOM_RST;
         col_q <= `DSP_GEOM_RST;
         reg_rdata <= 32'h0;
      end else begin
         if (reg_wr || ser_wr_q) begin
            case (reg_wr ? reg_addr : ser_ra_q)
               `DSP_A_CTRL: ctrl_q <= reg_wr ? reg_wdata : ser_wd_q;
               `DSP_A_DENS: dens_q <= reg_wr ? reg_wdata : ser_wd_q;
               `DSP_A_ROW: row_q <= reg_wr ? reg_wdata : ser_wd_q;
               `DSP_A_COL: col_q <= reg_wr ? reg_wdata : ser_wd_q;
               default: ;
            endcase
         end
         reg_rdata <= 32'h0;
         if (reg_rd) begin
            case (reg_addr)
               `DSP_A_CTRL: reg_rdata <= {24'h0, ctrl_q};
               `DSP_A_DENS: reg_rdata <= {24'h0, dens_q};
               `DSP_A_ROW: reg_rdata <= {24'h0, row_q};
               `DSP_A_COL: reg_rdata <= {24'h0, col_q};
               `DSP_A_STAT: reg_rdata <= {7'h0, eff_col, 1'b0, eff_row,
                  cfg_ok, err_q, mem_ready, 3'h0, st_q};
               default: reg_rdata <= 32'h0;
            endcase
         end
      end
   end

   // Two-wire configuration port; pins pass three flip-flops.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         ser_act_q <= 1'b0;
         ser_ack_q <= 1'b0;
         bit_q <= 4'h0;
         byte_q <= 2'h0;
         sh_q <= 8'h0;
         ser_ra_q <= 8'h0;
         ser_wd_q <= 8'h0;
         ser_wr_q <= 1'b0;
         cfg_serial_data_drive_en <= 1'b0;
      end else begin
         scl_s_q <= {scl_s_q[1:0], cfg_serial_clk_in};
         sda_s_q <= {sda_s_q[1:0], cfg_serial_data_in};
         if (scl_s_q[2] == scl_s_q[1])
            scl_q <= scl_s_q[1];
         sda_q <= sda_new;
         ser_wr_q <= 1'b0;
         if (ser_start || ser_stop) begin
            ser_act_q <= ser_start;
            ser_ack_q <= 1'b0;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            cfg_serial_data_drive_en <= 1'b0;
         end else if (ser_act_q && scl_rise && !ser_ack_q) begin
            sh_q <= {sh_q[6:0], sda_q};
            bit_q <= bit_q + 4'h1;
         end else if (ser_act_q && scl_fall) begin
            if (ser_ack_q) begin
               ser_ack_q <= 1'b0;
               bit_q <= 4'h0;
               cfg_serial_data_drive_en <= 1'b0;
            end else if (bit_q == 4'h8) begin
               ser_ack_q <= 1'b1;
               cfg_serial_data_drive_en <= 1'b1;
               if (byte_q == 2'h0) begin
                  if (sh_q != {SER_ADDR[6:0], 1'b0}) begin
                     ser_act_q <= 1'b0;
                     ser_ack_q <= 1'b0;
                     cfg_serial_data_drive_en <= 1'b0;
                  end
                  byte_q <= 2'h1;
               end else if (byte_q == 2'h1) begin
                  ser_ra_q <= sh_q;
                  byte_q <= 2'h2;
               end else begin
                  ser_wd_q <= sh_q;
                  ser_wr_q <= 1'b1;
               end
            end
         end
         if (ser_wr_q)
            ser_ra_q <= ser_ra_q + 8'h04;
      end
   end

   // Command selection for the next memory clock.
   always @* begin
      cmd = `DSP_CMD_NOP;
      case (st_q)
         S_IDLE, S_RST, S_CKE: cmd = `DSP_CMD_DES;
         S_MRS: cmd = (cnt_q == 20'h0) ? `DSP_CMD_MRS : `DSP_CMD_NOP;
         S_ZQ: cmd = (cnt_q == 20'h0) ? `DSP_CMD_ZQ : `DSP_CMD_NOP;
         S_READY: cmd = (usr_req && !usr_busy) ? `DSP_CMD_ACT :
            `DSP_CMD_NOP;
         S_ACT: cmd = (cnt_q == `DSP_T_RCD_CK) ?
            (we_q ? `DSP_CMD_WR : `DSP_CMD_RD) : `DSP_CMD_NOP;
         S_PRE: cmd = (cnt_q == 20'h0) ? `DSP_CMD_PRE : `DSP_CMD_NOP;
         default: cmd = `DSP_CMD_NOP;
      endcase
   end

   // Startup sequencer and single access engine.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= S_IDLE;
         cnt_q <= 20'h0;
         mr_q <= 2'h0;
         we_q <= 1'b0;
         err_q <= 1'b0;
         mem_ready <= 1'b0;
         usr_busy <= 1'b0;
         usr_done <= 1'b0;
         usr_rdata <= {DQ_W{1'b0}};
         dq_s1_q <= {DQ_W{1'b0}};
         dq_s2_q <= {DQ_W{1'b0}};
         mem_clock_p <= 1'b0;
         mem_clock_n <= 1'b1;
         mem_cke <= 1'b0;
         {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= `DSP_CMD_DES;
         mem_reset_n <= 1'b0;
         mem_termination_ctl <= 1'b0;
         mem_addr <= 16'h0;
         mem_bank <= 3'h0;
         mem_byte_mask <= {LN{1'b0}};
         mem_dq_out <= {DQ_W{1'b0}};
         mem_dq_oe <= {DQ_W{1'b0}};
         mem_dqs_p_out <= {LN{1'b0}};
         mem_dqs_n_out <= {LN{1'b1}};
         mem_dqs_oe <= {LN{1'b0}};
      end else begin
         mem_clock_p <= ~mem_clock_p;
         mem_clock_n <= mem_clock_p;
         dq_s1_q <= mem_dq_in;
         dq_s2_q <= dq_s1_q;
         usr_done <= 1'b0;
         if (hold) begin
            st_q <= S_IDLE;
            mem_ready <= 1'b0;
            usr_busy <= 1'b0;
            mem_cke <= 1'b0;
            mem_reset_n <= 1'b0;
            mem_termination_ctl <= 1'b0;
            {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= `DSP_CMD_DES;
            mem_dq_oe <= {DQ_W{1'b0}};
            mem_dqs_oe <= {LN{1'b0}};
         end else if (tick) begin
            {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= cmd;
            cnt_q <= cnt_q + 20'h1;
            case (st_q)
               S_IDLE: begin
                  if (startup_ctrl_go) begin
                     err_q <= !cfg_ok;
                     if (cfg_ok) begin
                        st_q <= S_RST;
                        cnt_q <= 20'h0;
                     end
                  end
               end
               S_RST: begin
                  mem_reset_n <= 1'b0;
                  if (cnt_q >= RST_CK[19:0] - 20'h1) begin
                     st_q <= S_CKE;
                     cnt_q <= 20'h0;
                     mem_reset_n <= 1'b1;
                  end
               end
               S_CKE: begin
                  if (cnt_q >= CKE_CK[19:0] - 20'h1) begin
                     st_q <= S_MRS;
                     cnt_q <= 20'h0;
                     mr_q <= 2'h0;
                     mem_cke <= 1'b1;
                  end
               end
               S_MRS: begin
                  mem_bank <= {1'b0, `DSP_MR_LAST - mr_q};
                  mem_addr <= 16'h0;
                  if (cnt_q == `DSP_T_MRD_CK) begin
                     cnt_q <= 20'h0;
                     mr_q <= mr_q + 2'h1;
                     if (mr_q == `DSP_MR_LAST)
                        st_q <= S_ZQ;
                  end
               end
               S_ZQ: begin
                  mem_addr <= 16'h0400;
                  if (cnt_q == `DSP_T_ZQ_CK) begin
                     st_q <= S_READY;
                     mem_ready <= 1'b1;
                  end
               end
               S_READY: begin
                  cnt_q <= 20'h0;
                  if (usr_req && !usr_busy) begin
                     // row and bank on the pads
                     mem_addr <= usr_row;
                     mem_bank <= usr_bank;
                     we_q <= usr_we;
                     usr_busy <= 1'b1;
                     st_q <= S_ACT;
                  end
               end
               S_ACT: begin
                  if (cnt_q == `DSP_T_RCD_CK) begin
                     mem_addr <= usr_col;
                     cnt_q <= 20'h0;
                     st_q <= S_XFER;
                  end
               end
               S_XFER: begin
                  if (we_q && cnt_q == WR_LAT) begin
                     mem_dq_out <= usr_wdata;
                     mem_byte_mask <= usr_wmask & lane_en;
                     mem_termination_ctl <= 1'b1;
                     for (i = 0; i < DQ_W; i = i + 1)
                        mem_dq_oe[i] <= lane_en[i / 8];
                     mem_dqs_oe <= lane_en;
                  end
                  if (!we_q && cnt_q == RD_LAT + 2)
                     usr_rdata <= dq_s2_q;
                  if (cnt_q == `DSP_BURST_CK + WR_LAT + RD_LAT) begin
                     mem_dq_oe <= {DQ_W{1'b0}};
                     mem_dqs_oe <= {LN{1'b0}};
                     mem_termination_ctl <= 1'b0;
                     mem_byte_mask <= {LN{1'b0}};
                     mem_addr <= 16'h0400;
                     cnt_q <= 20'h0;
                     st_q <= S_PRE;
                  end
               end
               S_PRE: begin
                  if (cnt_q == `DSP_T_RP_CK) begin
                     usr_busy <= 1'b0;
                     usr_done <= 1'b1;
                     st_q <= S_READY;
                  end
               end
               default: st_q <= S_IDLE;
            endcase
         end
         // Strobes toggle in step with the clock while driven.
         if (!hold) begin
            mem_dqs_p_out <= {LN{~mem_clock_p}};
            mem_dqs_n_out <= {LN{mem_clock_p}};
         end
      end
   end
endmodule

// ### test/dsp_checker.sv
// Port-level assertions for the DRAM startup and pad block.
`timescale 1ns/1ps
`include "dsp_regs.vh"
module dsp_checker #(
   parameter DQ_W = 32
) (
   input wire clk,
   input wire reset_n,
   input wire startup_ctrl_reset,
   input wire mem_master_reset_n,
   input wire cfg_serial_clk_in,
   input wire cfg_serial_data_drive_en,
   input wire usr_we,
   input wire [2:0] usr_bank,
   input wire [15:0] usr_row,
   input wire usr_done,
   input wire usr_busy,
   input wire mem_ready,
   input wire mem_clock_p,
   input wire mem_clock_n,
   input wire mem_cke,
   input wire mem_cs_n,
   input wire mem_ras_n,
   input wire mem_cas_n,
   input wire mem_we_n,
   input wire mem_reset_n,
   input wire mem_termination_ctl,
   input wire [15:0] mem_addr,
   input wire [2:0] mem_bank,
   input wire [DQ_W-1:0] mem_dq_oe,
   input wire [DQ_W/8-1:0] mem_dqs_p_out,
   input wire [DQ_W/8-1:0] mem_dqs_n_out,
   input wire [DQ_W/8-1:0] mem_dqs_oe
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   wire [3:0] cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};

   clk_pair_a: assert property (
      reset_n |=> mem_clock_p != $past(mem_clock_p) &&
      mem_clock_n == !mem_clock_p)
      else $error("memory clock pair not toggling in antiphase");
   seq_reset_a: assert property (
      startup_ctrl_reset |=> !mem_ready)
      else $error("ready survived startup reset");
   master_reset_a: assert property (
      !mem_master_reset_n |=> !mem_ready)
      else $error("ready survived master reset");
   ready_pins_a: assert property (
      mem_ready |-> mem_cke && mem_reset_n)
      else $error("ready without clock enable or reset release");
   busy_ready_a: assert property (
      usr_busy |-> mem_ready)
      else $error("access while not initialised");
   act_cmd_a: assert property (
      $rose(usr_busy) |-> ##[0:2] (cmd == `DSP_CMD_ACT &&
      mem_bank == usr_bank && mem_addr == usr_row))
      else $error("activate missing or wrong row or bank");
   drive_dir_a: assert property (
      mem_dq_oe != 0 |-> usr_busy && usr_we && mem_dqs_oe != 0 &&
      mem_termination_ctl)
      else $error("data bus driven outside a write");
   done_pulse_a: assert property (
      usr_done |=> !usr_done && !usr_busy)
      else $error("done not a single pulse ending busy");
   ack_phase_a: assert property (
      $changed(cfg_serial_data_drive_en) |-> !cfg_serial_clk_in)
      else $error("serial data drive changed with clock high");
   ack_len_a: assert property (
      $rose(cfg_serial_data_drive_en) |=> cfg_serial_data_drive_en [*8])
      else $error("serial acknowledge too short");
   strobe_pair_a: assert property (
      mem_dqs_oe != 0 |-> mem_dqs_n_out == ~mem_dqs_p_out &&
      mem_dqs_p_out != $past(mem_dqs_p_out))
      else $error("driven data strobe pair not toggling in antiphase");

   ready_c: cover property ($rose(mem_ready));
   write_c: cover property (mem_dq_oe != 0);
   ack_c: cover property ($rose(cfg_serial_data_drive_en));
endmodule

bind dsp_top dsp_checker #(.DQ_W(DQ_W)) i_chk (.*);

// ### test/dsp_mem_model.sv
// Memory chip model: keeps written bytes and returns them on reads.
`timescale 1ns/1ps
`include "dsp_regs.vh"
module dsp_mem_model #(
   parameter DQ_W = 32,
   parameter RL = 6
) (
   input wire clk,
   input wire [3:0] cmd,
   input wire [DQ_W-1:0] dq_out,
   input wire [DQ_W-1:0] dq_oe,
   input wire [DQ_W/8-1:0] mask,
   output wire [DQ_W-1:0] dq_drv
);
   logic [DQ_W-1:0] mem_q = '0;
   logic [DQ_W-1:0] drv_q = '0;
   logic [3:0] prev_q = 4'hf;
   int cnt = 99;
   assign dq_drv = drv_q;
   always @(posedge clk) begin
      prev_q <= cmd;
      // Only driven lanes whose mask bit is low are stored.
      for (int i = 0; i < DQ_W / 8; i++)
         if (dq_oe[8*i] && !mask[i])
            mem_q[8*i +: 8] <= dq_out[8*i +: 8];
      if (cmd == `DSP_CMD_RD && prev_q != cmd)
         cnt <= 0;
      else if (cnt < 99)
         cnt <= cnt + 1;
      // Outside the burst the lines invert every cycle, so stale data never holds for two cycles.
      if (cnt >= 2 * RL && cnt < 2 * RL + 8)
         drv_q <= mem_q;
      else
         drv_q <= ~drv_q;
   end
endmodule

// ### test/tb_top.sv
// Self-checking bench for the DRAM startup and pad block.
`timescale 1ns/1ps
`include "dsp_regs.vh"
module tb_top;
   logic clk, reset_n, reg_wr, reg_rd, usr_req, usr_we, sda_q;
   logic startup_ctrl_reset, startup_ctrl_go, mem_master_reset_n;
   logic cfg_serial_clk_in, cfg_serial_data_drive_en;
   logic usr_done, usr_busy, mem_ready, mem_clock_p, mem_clock_n, mem_cke;
   logic mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_reset_n;
   logic mem_termination_ctl;
   logic [7:0] reg_addr, reg_wdata;
   logic [2:0] usr_bank, mem_bank;
   logic [15:0] usr_row, usr_col, mem_addr;
   logic [31:0] reg_rdata, usr_wdata, usr_rdata, mem_dq_out, mem_dq_oe;
   logic [31:0] drv, oe_seen, v;
   logic [3:0] usr_wmask, mem_byte_mask, mem_dqs_p_out, mem_dqs_n_out;
   logic [3:0] mem_dqs_oe;
   wire [31:0] mem_dq_in;
   wire cfg_serial_data_in;
   wire [2:0] flags = {usr_done, usr_busy, mem_ready};
   wire [5:0] pins = {mem_reset_n, mem_cke, mem_cs_n, mem_ras_n,
      mem_cas_n, mem_we_n};
   int err_total = 0, check_count = 0, cycles = 0, n;

   dsp_top #(.RST_CK(20), .CKE_CK(30)) i_dut (.*);
   dsp_mem_model #(.DQ_W(32), .RL(6)) i_mem (
      .clk(clk),
      .cmd({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n}),
      .dq_out(mem_dq_out),
      .dq_oe(mem_dq_oe),
      .mask(mem_byte_mask),
      .dq_drv(drv)
   );
   assign mem_dq_in = (mem_dq_oe & mem_dq_out) | (~mem_dq_oe & drv);
   // The serial data line has a pull-up; the block may only pull it low.
   assign cfg_serial_data_in = sda_q & !cfg_serial_data_drive_en;

   // Steady clock standing in for the PLL output.
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      oe_seen <= oe_seen | mem_dq_oe;
      if (cycles == 60000) begin
         err_total++;
         final_report;
      end
   end

   task chk(string name, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task cyc(int k);
      repeat (k) @(posedge clk);
   endtask
   task till(int k);
      for (n = 0; n < 2000 && flags[k] !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
   endtask
   task wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 0;
   endtask
   task rd(logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 0;
      #1 v = reg_rdata;
   endtask
   task rchk(logic [7:0] a, logic [31:0] e);
      rd(a);
      chk("reg_read", e, v);
   endtask
   task go_wait;
      @(posedge clk);
      startup_ctrl_go <= 1;
      cyc(4);
      startup_ctrl_go <= 0;
      till(0);
   endtask
   task boot(logic [7:0] c, logic [7:0] d);
      @(posedge clk);
      startup_ctrl_reset <= 1;
      wr(`DSP_A_CTRL, c);
      wr(`DSP_A_DENS, d);
      startup_ctrl_reset <= 0;
      go_wait;
   endtask
   task acc(logic we, logic [31:0] d, logic [3:0] m);
      usr_req <= 1;
      usr_we <= we;
      usr_wdata <= d;
      usr_wmask <= m;
      till(1);
      usr_req <= 0;
      till(2);
      v = usr_rdata;
   endtask
   task automatic t_cfg;
      logic [7:0] c [8] = '{8'h10, 8'h00, 8'h00, 8'h01,
         8'h02, 8'h02, 8'h02, 8'h0c};
      logic [7:0] d [8] = '{8'h1a, 8'h18, 8'h02, 8'h00,
         8'h1a, 8'h14, 8'h25, 8'h24};
      logic [7:0] ok = 8'hc9;
      wr(`DSP_A_ROW, 8'h10);
      wr(`DSP_A_COL, 8'h0b);
      for (int k = 0; k < 8; k++) begin
         boot(c[k], d[k]);
         chk("ready", ok[k], mem_ready);
         rd(`DSP_A_STAT);
         chk("cfg_ok", {ok[k], !ok[k]}, v[9:8]);
         if (ok[k] && c[k][3])
            chk("geom", {7'h0b, 7'h10}, {v[24:18], v[16:10]});
         else if (ok[k])
            chk("geom", {7'h0a, 7'h0b + {4'h0, d[k][2:0]}},
               {v[24:18], v[16:10]});
      end
   endtask
   task t_access;
      oe_seen = '0;
      acc(1, 32'ha5c31e77, 4'h2);
      chk("lanes", 32'hffffffff, oe_seen);
      acc(0, 32'h0, 4'h0);
      chk("rdata", 32'ha5c30077, v);
      boot(8'h00, 8'h1a);
      oe_seen = '0;
      acc(1, 32'hffffffff, 4'h0);
      chk("lanes", 32'h0000ffff, oe_seen);
      acc(0, 32'h0, 4'h0);
      chk("rdata", 32'hffff, v[15:0]);
   endtask
   task t_master;
      mem_master_reset_n <= 0;
      cyc(3);
      mem_master_reset_n <= 1;
      cyc(100);
      #1 chk("ready", 0, mem_ready);
      go_wait;
      chk("ready", 1, mem_ready);
   endtask
   // Clock edge first, data a little later, so no false start or stop.
   task sline(logic c, logic d);
      cfg_serial_clk_in <= c;
      cyc(4);
      sda_q <= d;
      cyc(12);
   endtask
   task sbyte(logic [7:0] b, logic ack);
      for (int i = 7; i >= 0; i--) begin
         sline(0, b[i]);
         sline(1, b[i]);
      end
      sline(0, 1);
      #1 chk("ack", ack, cfg_serial_data_drive_en);
      sline(1, 1);
   endtask
   task t_serial;
      sline(1, 0);
      sbyte({7'h2a, 1'b0}, 1);
      sbyte(`DSP_A_DENS, 1);
      sbyte(8'h24, 1);
      sbyte(8'h11, 1);
      sline(0, 0);
      sline(1, 1);
      rchk(`DSP_A_DENS, 32'h24);
      rchk(`DSP_A_ROW, 32'h11);
      sline(1, 0);
      sbyte({7'h2b, 1'b0}, 0);
      sbyte(8'h33, 0);
      sline(0, 0);
      sline(1, 1);
      rchk(`DSP_A_DENS, 32'h24);
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      {reset_n, reg_wr, reg_rd, usr_req, usr_we, startup_ctrl_go} = '0;
      {startup_ctrl_reset, reg_addr, reg_wdata, usr_wdata, usr_wmask} = '0;
      {mem_master_reset_n, cfg_serial_clk_in, sda_q} = 3'h7;
      usr_bank = 3'h5;
      usr_row = 16'h1234;
      usr_col = 16'h0048;
      oe_seen = '0;
      cyc(5);
      #1 chk("idle_pins", 32'h0f, pins);
      chk("idle_oe", 32'h0, mem_dq_oe);
      @(posedge clk);
      reset_n <= 1;
      rchk(`DSP_A_CTRL, 32'h00);
      rchk(`DSP_A_DENS, 32'h1a);
      rchk(`DSP_A_ROW, 32'h0e);
      rchk(`DSP_A_COL, 32'h0e);
      rchk(8'h20, 32'h0);
      t_cfg;
      t_access;
      t_master;
      t_serial;
      final_report;
   end
endmodule
